// [src/lmr_regs.sv]
`timescale 1ns/100ps
`default_nettype none
// How it works
// R1: 4-bit led voltage code in low bits
// R2: done flag zero in progress, one done
// R3: shutdown bit blocks every conversion
// R4: manual mode adds conversions, auto continues
// R5: auto mode converts at each flash start
// R6: host read of monitor clears done flag
// R7: 5-bit delay, 250 us steps, before start
// R8: same delay for manual and automatic
// R9: no-delay bit starts conversion at once
// R10: supply monitors: enables and threshold codes
// R11: privacy source select bits, led1 default
// R12: terminate bit keeps privacy off after flash
// R13: 3-bit privacy duty, 10 to 80 percent
// R14: 3-bit privacy pwm period select
// R15: message ramp code and period count
// R16: 3-bit message current level code
// R17: unused bits read zero, writes ignored
module lmr_regs #(
  parameter int unsigned STEP_CYCLES = lmr_pkg::DELAY_STEP_CYCLES
) (
  input wire logic i_clock, // system clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic [7:0] i_reg_addr, // register address
  input wire logic i_reg_wr, // write strobe, one cycle
  input wire logic i_reg_rd, // read strobe, one cycle
  input wire logic [7:0] i_reg_wdata, // write data
  output logic [7:0] o_reg_rdata, // read data
  output logic o_reg_rvalid, // read data valid, one cycle
  input wire logic i_flash_start, // flash pulse begins, one cycle
  input wire logic i_flash_end, // flash pulse ends, one cycle
  input wire logic i_privacy_req, // privacy mode requested, level
  input wire logic i_conv_done, // converter finished, one cycle
  input wire logic [3:0] i_conv_code, // converter result
  output logic o_conv_start, // start a conversion, one cycle
  output logic o_conv_enable, // converter powered
  output logic [3:0] o_led_node_voltage, // last result code
  output logic o_supply_mon_en, // general supply monitor on
  output logic [1:0] o_supply_mon_thr, // general threshold code
  output logic o_flash_mon_en, // flash supply monitor on
  output logic [1:0] o_flash_mon_thr, // flash threshold code
  output logic o_privacy_led1, // drive first source for privacy
  output logic o_privacy_led2, // drive second source for privacy
  output logic [2:0] o_privacy_duty_code, // privacy current step
  output logic [1:0] o_privacy_blink, // privacy blink code
  output logic [lmr_pkg::PWM_W-1:0] o_pwm_period_cycles, // pwm period
  output logic [1:0] o_ramp_code, // message ramp time code
  output logic [2:0] o_period_count, // message period count
  output logic [2:0] o_indicator_level_code // message current step
);
  import lmr_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  // storage
  logic [7:0] mon_ctrl; // monitor control bits only
  logic eoc; // conversion-complete flag
  logic [3:0] result_code; // last conversion result
  logic [7:0] conv_delay; // delay register
  logic [7:0] supply_mon; // supply monitor register
  logic [7:0] privacy_ctl; // privacy register
  logic [7:0] privacy_pwm; // privacy pwm register
  logic [7:0] message_ind; // message indicator register
  logic flash_active; // inside a flash pulse
  logic privacy_held_off; // privacy stays off after a flash

  //////////////////////////////////////////////////////////////////////////
  // address decode
  wire sel_mon = (i_reg_addr == ADDR_LED_MONITOR);
  wire sel_dly = (i_reg_addr == ADDR_CONV_DELAY);
  wire sel_sup = (i_reg_addr == ADDR_SUPPLY_MONITOR);
  wire sel_prv = (i_reg_addr == ADDR_PRIVACY_CONTROL);
  wire sel_pwm = (i_reg_addr == ADDR_PRIVACY_PWM);
  wire sel_ind = (i_reg_addr == ADDR_MESSAGE_IND);
  wire wr_mon = i_reg_wr && sel_mon;
  wire rd_mon = i_reg_rd && sel_mon;

  // masked write data per register; unused bits never stored
  wire [7:0] wd_mon = i_reg_wdata & WMASK_LED_MONITOR;
  wire [7:0] wd_dly = i_reg_wdata & WMASK_CONV_DELAY;
  wire [7:0] wd_sup = i_reg_wdata & WMASK_SUPPLY_MONITOR;
  wire [7:0] wd_prv = i_reg_wdata & WMASK_PRIVACY_CONTROL;
  wire [7:0] wd_pwm = i_reg_wdata & WMASK_PRIVACY_PWM;
  wire [7:0] wd_ind = i_reg_wdata & WMASK_MESSAGE_IND;

  // shutdown as it will be after this cycle, so that a start can never
  // slip out in the very cycle the host shuts the converter down
  wire shutdown = mon_ctrl[MON_SHDN_BIT];
  wire next_shutdown = wr_mon ? wd_mon[MON_SHDN_BIT] : shutdown;
  wire manual_mode = mon_ctrl[MON_MANUAL_BIT];

  // R5: automatic conversion on every flash start
  wire auto_trig = i_flash_start;
  // R4: manual read re-arms, automatic trigger still active
  wire manual_trig = rd_mon && manual_mode;
  wire conv_trig = (auto_trig || manual_trig) && !next_shutdown;
  // done is dropped by a read or by a fresh trigger
  wire eoc_clear = rd_mon || conv_trig;
  wire done_ok = i_conv_done && !shutdown;

  // monitor register as seen by the host
  wire [7:0] mon_view = mon_ctrl | ({7'h00, eoc} << MON_EOC_BIT)
    | {4'h0, result_code};

  //////////////////////////////////////////////////////////////////////////
  // read mux; unmapped addresses answer zero
  wire [7:0] rd_mux =
    sel_mon ? mon_view :
    sel_dly ? conv_delay :
    sel_sup ? supply_mon :
    sel_prv ? privacy_ctl :
    sel_pwm ? privacy_pwm :
    sel_ind ? message_ind : UNMAPPED_DATA;

  // bits that may read as one at each address; all others are unused
  wire [7:0] used_bits =
    sel_mon ? (WMASK_LED_MONITOR | (8'h01 << MON_EOC_BIT) | 8'h0F) :
    sel_dly ? WMASK_CONV_DELAY :
    sel_sup ? WMASK_SUPPLY_MONITOR :
    sel_prv ? WMASK_PRIVACY_CONTROL :
    sel_pwm ? WMASK_PRIVACY_PWM :
    sel_ind ? WMASK_MESSAGE_IND : UNMAPPED_DATA;

  //////////////////////////////////////////////////////////////////////////
  // control registers; each field keeps only its used bits
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mon_ctrl <= RST_LED_MONITOR;
      conv_delay <= RST_CONV_DELAY;
      supply_mon <= RST_SUPPLY_MONITOR;
      privacy_ctl <= RST_PRIVACY_CONTROL;
      privacy_pwm <= RST_PRIVACY_PWM;
      message_ind <= RST_MESSAGE_IND;
    end else if (i_reg_wr) begin
      // R3: shutdown and manual bits
      // R17: masked writes
      if (sel_mon) mon_ctrl <= wd_mon;
      if (sel_dly) conv_delay <= wd_dly;
      // R10: supply monitor fields
      if (sel_sup) supply_mon <= wd_sup;
      if (sel_prv) privacy_ctl <= wd_prv;
      if (sel_pwm) privacy_pwm <= wd_pwm;
      if (sel_ind) message_ind <= wd_ind;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // done flag and result; a done arriving with a read wins
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      eoc <= 1'b0;
      result_code <= RST_RESULT_CODE;
    end else begin
      // R2: set on done, set beats clear
      // R6: read clears the flag
      if (done_ok) begin
        eoc <= 1'b1;
      end else if (eoc_clear) begin
        eoc <= 1'b0;
      end
      // R1: capture converter result
      if (done_ok) begin
        result_code <= i_conv_code;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read answer, one cycle after the strobe
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_reg_rdata <= 8'h00;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_rd;
      if (i_reg_rd) begin
        o_reg_rdata <= rd_mux;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // conversion start delay
  // R8: one timer serves both trigger sources
  lmr_conv_timer #(
    .STEP_CYCLES(STEP_CYCLES)
  ) u_timer (
    .i_clock(i_clock),
    .i_arst_n(i_arst_n),
    .i_arm(conv_trig),
    .i_abort(next_shutdown),
    .i_no_delay(conv_delay[DLY_NODELAY_BIT]),
    .i_delay_code(conv_delay[DELAY_CODE_W-1:0]),
    .o_start(o_conv_start),
    .o_busy()
  );

  //////////////////////////////////////////////////////////////////////////
  // privacy sequencing around the flash pulse
  wire next_flash_active = i_flash_start ? 1'b1 :
    (i_flash_end ? 1'b0 : flash_active);
  // R12: hold off until the request drops
  wire next_held_off = !i_privacy_req ? 1'b0 :
    ((i_flash_end && privacy_ctl[PRV_TERM_BIT]) ? 1'b1 : privacy_held_off);
  wire privacy_on = i_privacy_req && !next_flash_active && !next_held_off;

  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      flash_active <= 1'b0;
      privacy_held_off <= 1'b0;
      o_privacy_led1 <= 1'b0;
      o_privacy_led2 <= 1'b0;
    end else begin
      flash_active <= next_flash_active;
      privacy_held_off <= next_held_off;
      // R11: source select
      o_privacy_led1 <= privacy_on && privacy_ctl[PRV_LED1_BIT];
      o_privacy_led2 <= privacy_on && privacy_ctl[PRV_LED2_BIT];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // field outputs, registered copies of the stored settings
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_conv_enable <= 1'b0;
      o_led_node_voltage <= RST_RESULT_CODE;
      o_supply_mon_en <= 1'b0;
      o_supply_mon_thr <= 2'h0;
      o_flash_mon_en <= 1'b0;
      o_flash_mon_thr <= 2'h0;
      o_privacy_duty_code <= 3'h0;
      o_privacy_blink <= 2'h0;
      o_pwm_period_cycles <= '0;
      o_ramp_code <= 2'h0;
      o_period_count <= 3'h0;
      o_indicator_level_code <= 3'h0;
    end else begin
      // R3: converter powered unless shut down
      o_conv_enable <= !next_shutdown;
      o_led_node_voltage <= result_code;
      o_supply_mon_en <= supply_mon[0];
      o_supply_mon_thr <= supply_mon[2:1];
      o_flash_mon_en <= supply_mon[3];
      o_flash_mon_thr <= supply_mon[5:4];
      // R13: duty step
      o_privacy_duty_code <= privacy_ctl[2:0];
      o_privacy_blink <= privacy_ctl[7:6];
      // R14: period decode
      o_pwm_period_cycles <= lmr_pwm_cycles(privacy_pwm[2:0]);
      // R15: ramp and count
      o_ramp_code <= message_ind[7:6];
      o_period_count <= message_ind[5:3];
      // R16: current step
      o_indicator_level_code <= message_ind[2:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // checks
  a_read_clears_eoc: assert property ( // R6
    @(posedge i_clock) disable iff (!i_arst_n)
    (rd_mon && !done_ok) |=> !eoc)
    else $error("monitor read did not clear done flag");

  a_done_sets_eoc: assert property ( // R2
    @(posedge i_clock) disable iff (!i_arst_n)
    done_ok |=> (eoc && result_code == $past(i_conv_code)))
    else $error("done did not set flag and result");

  a_no_start_shut: assert property ( // R3
    @(posedge i_clock) disable iff (!i_arst_n)
    shutdown |-> !o_conv_start)
    else $error("conversion started while shut down");

  a_auto_flash_arm: assert property ( // R5
    @(posedge i_clock) disable iff (!i_arst_n)
    (i_flash_start && !next_shutdown && !done_ok) |=> !eoc)
    else $error("flash start did not begin a conversion");

  a_reserved_read_zero: assert property ( // R17
    @(posedge i_clock) disable iff (!i_arst_n)
    o_reg_rvalid |-> ((o_reg_rdata & ~$past(used_bits)) == 8'h00))
    else $error("unused bit read as one");

  a_privacy_select: assert property ( // R11
    @(posedge i_clock) disable iff (!i_arst_n)
    (o_privacy_led1 || o_privacy_led2) |->
      ($past(i_privacy_req) && !flash_active))
    else $error("privacy source on without request");

  a_privacy_after_flash: assert property ( // R12
    @(posedge i_clock) disable iff (!i_arst_n)
    (i_flash_end && i_privacy_req && privacy_ctl[PRV_TERM_BIT]
      && !i_flash_start) ##1 i_privacy_req |=> !o_privacy_led1)
    else $error("privacy came back after terminating flash");

  a_pwm_fast_code: assert property ( // R14
    @(posedge i_clock) disable iff (!i_arst_n)
    privacy_pwm[2] |=> (o_pwm_period_cycles ==
      PWM_W'((PWM_P4_NS * 1000) / CLK_PERIOD_PS)))
    else $error("pwm period wrong for top code");

endmodule
`default_nettype wire

// [shared/lmr_pkg.sv]
`default_nettype none
package lmr_pkg;

  // clock of the register block: 200 MHz
  localparam int unsigned CLK_PERIOD_PS = 5000;

  // conversion start delay: one step per code, code 0 is one step
  localparam int unsigned DELAY_STEP_US = 250;
  // a least time, so round up to whole cycles
  localparam int unsigned DELAY_STEP_CYCLES =
    (DELAY_STEP_US * 1000 * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int unsigned DELAY_CODE_W = 5;

  // register addresses on the host port
  localparam logic [7:0] ADDR_LED_MONITOR = 8'h00;
  localparam logic [7:0] ADDR_CONV_DELAY = 8'h01;
  localparam logic [7:0] ADDR_SUPPLY_MONITOR = 8'h02;
  localparam logic [7:0] ADDR_PRIVACY_CONTROL = 8'h03;
  localparam logic [7:0] ADDR_PRIVACY_PWM = 8'h04;
  localparam logic [7:0] ADDR_MESSAGE_IND = 8'h05;

  // answer to an unmapped address
  localparam logic [7:0] UNMAPPED_DATA = 8'h00;

  // writable bits of each register; unused bits read zero
  localparam logic [7:0] WMASK_LED_MONITOR = 8'h30;
  localparam logic [7:0] WMASK_CONV_DELAY = 8'h3F;
  localparam logic [7:0] WMASK_SUPPLY_MONITOR = 8'h3F;
  localparam logic [7:0] WMASK_PRIVACY_CONTROL = 8'hFF;
  localparam logic [7:0] WMASK_PRIVACY_PWM = 8'h07;
  localparam logic [7:0] WMASK_MESSAGE_IND = 8'hFF;

  // reset values
  localparam logic [7:0] RST_LED_MONITOR = 8'h00;
  localparam logic [7:0] RST_CONV_DELAY = 8'h00;
  localparam logic [7:0] RST_SUPPLY_MONITOR = 8'h00;
  localparam logic [7:0] RST_PRIVACY_CONTROL = 8'h58;
  localparam logic [7:0] RST_PRIVACY_PWM = 8'h00;
  localparam logic [7:0] RST_MESSAGE_IND = 8'h00;
  localparam logic [3:0] RST_RESULT_CODE = 4'h0;

  // field positions
  localparam int unsigned MON_EOC_BIT = 6;
  localparam int unsigned MON_SHDN_BIT = 5;
  localparam int unsigned MON_MANUAL_BIT = 4;
  localparam int unsigned DLY_NODELAY_BIT = 5;
  localparam int unsigned PRV_LED2_BIT = 5;
  localparam int unsigned PRV_LED1_BIT = 4;
  localparam int unsigned PRV_TERM_BIT = 3;

  // privacy pwm periods
  localparam int unsigned PWM_P0_NS = 5120000;
  localparam int unsigned PWM_P1_NS = 2560000;
  localparam int unsigned PWM_P2_NS = 1280000;
  localparam int unsigned PWM_P3_NS = 640000;
  localparam int unsigned PWM_P4_NS = 320000;
  localparam int unsigned PWM_W = 21;

  // period code to a count of clock cycles
  function automatic logic [PWM_W-1:0] lmr_pwm_cycles(
    input logic [2:0] code
  );
    int unsigned ns;
    ns = PWM_P4_NS;
    case (code)
      3'h0: ns = PWM_P0_NS;
      3'h1: ns = PWM_P1_NS;
      3'h2: ns = PWM_P2_NS;
      3'h3: ns = PWM_P3_NS;
      default: ns = PWM_P4_NS;
    endcase
    // widen first: the longest period times 1000 overflows 32 bits
    return PWM_W'((64'(ns) * 1000) / CLK_PERIOD_PS);
  endfunction

endpackage
`default_nettype wire

// [src/lmr_conv_timer.sv]
`timescale 1ns/100ps
`default_nettype none
module lmr_conv_timer #(
  parameter int unsigned STEP_CYCLES = lmr_pkg::DELAY_STEP_CYCLES
) (
  input wire logic i_clock, // system clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_arm, // conversion trigger: begin the wait
  input wire logic i_abort, // converter shut down
  input wire logic i_no_delay, // start right away
  input wire logic [lmr_pkg::DELAY_CODE_W-1:0] i_delay_code, // wait steps
  output logic o_start, // one-cycle conversion start
  output logic o_busy // a wait is running
);
  import lmr_pkg::*;

  typedef enum logic [1:0] {
    LMR_IDLE = 2'b01,
    LMR_WAIT = 2'b10
  } lmr_tstate_t;

  lmr_tstate_t state; // sequencer state
  logic [31:0] step_cnt; // cycles left in the current step
  logic [DELAY_CODE_W-1:0] steps_left; // whole steps still to go
  wire step_end = (step_cnt == 32'h0);
  wire last_step = (steps_left == '0);

  //////////////////////////////////////////////////////////////////////////
  // wait sequencer; a fresh arm restarts the wait from the new code
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      state <= LMR_IDLE;
      step_cnt <= 32'h0;
      steps_left <= '0;
      o_start <= 1'b0;
    end else begin
      o_start <= 1'b0;
      case (state)
        LMR_IDLE: begin
          // shutdown wins over any pending start
          if (i_arm && !i_abort) begin
            // R9: no-delay bit
            if (i_no_delay) begin
              o_start <= 1'b1;
            end else begin
              // R7: programmable start delay
              state <= LMR_WAIT;
              step_cnt <= STEP_CYCLES - 1;
              steps_left <= i_delay_code;
            end
          end
        end
        LMR_WAIT: begin
          if (i_abort) begin
            state <= LMR_IDLE;
          end else if (i_arm) begin
            // restart; same path as from idle
            if (i_no_delay) begin
              o_start <= 1'b1;
              state <= LMR_IDLE;
            end else begin
              step_cnt <= STEP_CYCLES - 1;
              steps_left <= i_delay_code;
            end
          end else if (step_end && last_step) begin
            o_start <= 1'b1;
            state <= LMR_IDLE;
          end else if (step_end) begin
            steps_left <= steps_left - 1'b1;
            step_cnt <= STEP_CYCLES - 1;
          end else begin
            step_cnt <= step_cnt - 32'h1;
          end
        end
        default: state <= LMR_IDLE;
      endcase
    end
  end

  assign o_busy = (state == LMR_WAIT);

  //////////////////////////////////////////////////////////////////////////
  // helper: cycles since the last arm, and the settings taken then
  logic [31:0] since_arm;
  logic [DELAY_CODE_W-1:0] cap_code;
  logic cap_nd;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      since_arm <= 32'h0;
      cap_code <= '0;
      cap_nd <= 1'b0;
    end else if (i_arm) begin
      since_arm <= 32'h1;
      cap_code <= i_delay_code;
      cap_nd <= i_no_delay;
    end else begin
      since_arm <= since_arm + 32'h1;
    end
  end

  a_start_delay_len: assert property ( // R7
    @(posedge i_clock) disable iff (!i_arst_n)
    // a start raised at an edge is seen one edge later, hence the + 1
    o_start |-> (cap_nd ? since_arm == 32'h1 :
      since_arm == (32'(cap_code) + 32'h1) * STEP_CYCLES + 32'h1))
    else $error("conversion start at wrong delay");

  a_no_delay_now: assert property ( // R9
    @(posedge i_clock) disable iff (!i_arst_n)
    (i_arm && i_no_delay && !i_abort) |=> o_start)
    else $error("no-delay start not immediate");

  a_same_delay_both: assert property ( // R8
    @(posedge i_clock) disable iff (!i_arst_n)
    (i_arm && !i_no_delay && !i_abort) |=> (!o_start && o_busy))
    else $error("delayed start did not wait");

endmodule
`default_nettype wire

// [dv/lmr_conv_model.sv]
`timescale 1ns/100ps
`default_nettype none
// converter stand-in: answers the latest start after a fixed latency
module lmr_conv_model #(
  parameter int LAT = 3 // cycles from start to done
) (
  input wire logic i_clock, // system clock
  input wire logic i_arst_n, // async reset, active low
  input wire logic i_start, // start pulse from the block
  input wire logic [3:0] i_next_code, // code for the next answer
  output logic o_done, // one-cycle done pulse
  output logic [3:0] o_code // result, only valid with done
);
  int cnt = 0; // cycles to go, zero when idle
  // outside the done pulse the code wanders, so a late sample shows
  always @(negedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) begin
      cnt <= 0;
      o_done <= 1'b0;
      o_code <= 4'h5;
    end else begin
      o_done <= (cnt == 1);
      o_code <= (cnt == 1) ? i_next_code : ~o_code;
      // a new start restarts the count
      if (i_start) begin
        cnt <= LAT;
      end else if (cnt != 0) begin
        cnt <= cnt - 1;
      end
    end
  end
endmodule
`default_nettype wire

// [dv/testbench.sv]
`timescale 1ns/100ps
`default_nettype none
module testbench;
  import lmr_pkg::*;
  localparam int STEP = 4; // shortened delay step keeps runs short
  logic i_clock = 1'b0;
  logic i_arst_n = 1'b1; // dropped at time zero for a clean edge
  logic [7:0] addr = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] wdata = 8'h00;
  logic fstart = 1'b0;
  logic fend = 1'b0;
  logic preq = 1'b0;
  logic [3:0] next_code = 4'h0; // code the converter reports next
  logic cdone, rvalid, cstart, cen, sen, fen, led1, led2;
  logic [3:0] ccode, vout;
  logic [7:0] rdata;
  logic [1:0] sthr, fthr, blink, ramp;
  logic [2:0] duty, pcnt, ilvl;
  logic [PWM_W-1:0] pwm;
  logic [7:0] rstv [7] = '{8'h00, 8'h00, 8'h00, 8'h58, 8'h00, 8'h00, 8'h00};
  logic [7:0] msk [7] = '{8'h30, 8'h3F, 8'h3F, 8'hFF, 8'h07, 8'hFF, 8'h00};
  logic [7:0] wv [7];
  logic [7:0] expq [$]; // read results still owed
  integer seed = 32'ha547a3d2;
  int error_cnt = 0;
  int samples_checked = 0;
  int cycles = 0;
  int n;

  lmr_regs #(.STEP_CYCLES(STEP)) i_dut (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_reg_addr(addr),
    .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_wdata(wdata),
    .o_reg_rdata(rdata), .o_reg_rvalid(rvalid), .i_flash_start(fstart),
    .i_flash_end(fend), .i_privacy_req(preq), .i_conv_done(cdone),
    .i_conv_code(ccode), .o_conv_start(cstart), .o_conv_enable(cen),
    .o_led_node_voltage(vout), .o_supply_mon_en(sen),
    .o_supply_mon_thr(sthr), .o_flash_mon_en(fen),
    .o_flash_mon_thr(fthr), .o_privacy_led1(led1), .o_privacy_led2(led2),
    .o_privacy_duty_code(duty), .o_privacy_blink(blink),
    .o_pwm_period_cycles(pwm), .o_ramp_code(ramp),
    .o_period_count(pcnt), .o_indicator_level_code(ilvl));

  lmr_conv_model #(.LAT(3)) i_conv (
    .i_clock(i_clock), .i_arst_n(i_arst_n), .i_start(cstart),
    .i_next_code(next_code), .o_done(cdone), .o_code(ccode));

  always #2.5 i_clock = ~i_clock;

  task automatic check(input string what, input logic [31:0] seen,
                       input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // one-cycle write strobe
  task automatic wreg(input int a, input logic [7:0] d);
    @(negedge i_clock);
    addr = 8'(a);
    wdata = d;
    wr = 1'b1;
    @(negedge i_clock);
    wr = 1'b0;
  endtask

  // one-cycle read strobe; the answer is owed to the watcher
  task automatic rreg(input int a, input logic [7:0] exp);
    @(negedge i_clock);
    addr = 8'(a);
    rd = 1'b1;
    expq.push_back(exp);
    @(negedge i_clock);
    rd = 1'b0;
  endtask

  // flash start or end pulse of one cycle
  task automatic flash(input bit e);
    @(negedge i_clock);
    if (e) fend = 1'b1;
    else fstart = 1'b1;
    @(negedge i_clock);
    fstart = 1'b0;
    fend = 1'b0;
  endtask

  // cycles from the trigger edge to a start pulse, 0 if none came
  task automatic wait_start(output int k);
    k = 0;
    for (int i = 1; i < 300 && k == 0; i++) begin
      @(negedge i_clock);
      if (cstart === 1'b1) k = i;
    end
  endtask

  // read answers come one cycle later, compared in order
  always @(negedge i_clock) begin
    if (rvalid === 1'b1) begin
      if (expq.size() == 0) check("stray read", 1, 0);
      else check("reg read", rdata, expq.pop_front());
    end
  end

  // hang guard
  always @(posedge i_clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      close_out();
    end
  end

  initial begin
    i_arst_n = 1'b0;
    repeat (6) @(negedge i_clock);
    i_arst_n = 1'b1;
    for (int a = 0; a < 7; a++) rreg(a, rstv[a]);
    check("pwm reset", pwm, 1024000);
    $display("test reset done");
    for (int a = 1; a < 7; a++) begin
      wv[a] = 8'($random(seed));
      wreg(a, wv[a]);
      rreg(a, wv[a] & msk[a]);
    end
    wreg(ADDR_LED_MONITOR, 8'hCF);
    rreg(ADDR_LED_MONITOR, 8'h00);
    check("supply", {sthr, sen, fthr, fen}, {wv[2][2:0], wv[2][5:3]});
    check("privacy", {blink, duty}, {wv[3][7:6], wv[3][2:0]});
    check("message", {ramp, pcnt, ilvl}, wv[5]);
    $display("test fields done");
    for (int c = 0; c < 8; c++) begin
      wreg(ADDR_PRIVACY_PWM, 8'(c));
      repeat (2) @(negedge i_clock);
      check("pwm", pwm, c > 3 ? 64000 : 1024000 >> c);
    end
    $display("test pwm done");
    wreg(ADDR_CONV_DELAY, 8'h20);
    next_code = 4'hF;
    flash(0);
    check("start no delay", cstart, 1);
    wait_start(n);
    check("single start", n, 0);
    repeat (8) @(negedge i_clock);
    check("voltage", vout, 4'hF);
    rreg(ADDR_LED_MONITOR, 8'h4F);
    rreg(ADDR_LED_MONITOR, 8'h0F);
    $display("test immediate done");
    for (int i = 0; i < 3; i++) begin
      n = (i == 2) ? 31 : i * 2;
      wreg(ADDR_CONV_DELAY, 8'(n));
      next_code = 4'($random(seed));
      flash(0);
      wait_start(n);
      check("start delay", n, ((i == 2) ? 32 : i * 2 + 1) * STEP);
      repeat (8) @(negedge i_clock);
    end
    // manual read starts a delayed one, auto still runs
    wreg(ADDR_CONV_DELAY, 8'h05);
    wreg(ADDR_LED_MONITOR, 8'h10);
    rreg(ADDR_LED_MONITOR, {4'h5, next_code});
    wait_start(n);
    check("manual delay", n, 6 * STEP);
    repeat (8) @(negedge i_clock);
    flash(0);
    wait_start(n);
    check("auto in manual", n, 6 * STEP);
    repeat (8) @(negedge i_clock);
    $display("test delay done");
    wreg(ADDR_LED_MONITOR, 8'h20);
    repeat (2) @(negedge i_clock);
    check("conv enable", cen, 0);
    flash(0);
    wait_start(n);
    check("no start", n, 0);
    wreg(ADDR_LED_MONITOR, 8'h00);
    repeat (2) @(negedge i_clock);
    check("conv enable", cen, 1);
    $display("test shutdown done");
    wreg(ADDR_PRIVACY_CONTROL, 8'h38);
    flash(1); // earlier flash starts left the pulse open
    preq = 1'b1;
    repeat (3) @(negedge i_clock);
    check("both sources", {led1, led2}, 2'b11);
    flash(0);
    repeat (2) @(negedge i_clock);
    check("off in flash", {led1, led2}, 2'b00);
    flash(1);
    repeat (3) @(negedge i_clock);
    check("stays off", {led1, led2}, 2'b00);
    preq = 1'b0;
    wreg(ADDR_PRIVACY_CONTROL, 8'h20);
    preq = 1'b1;
    repeat (3) @(negedge i_clock);
    check("second only", {led1, led2}, 2'b01);
    flash(0);
    flash(1);
    repeat (3) @(negedge i_clock);
    check("back on", {led1, led2}, 2'b01);
    $display("test privacy done");
    repeat (4) @(negedge i_clock);
    close_out();
  end
endmodule
`default_nettype wire
